// [common/hwrd_map.svh]
// constants for the host write request decoder
`ifndef HWRD_MAP_SVH
`define HWRD_MAP_SVH

// ----------------------------------------------------------------------
// field widths of a request with data and of its completion code
// ----------------------------------------------------------------------
`define HWRD_OPC_W      4
`define HWRD_META_W     2
`define HWRD_SNP_W      3
`define HWRD_ADDR_W     46
`define HWRD_TAG_W      16
`define HWRD_TC_W       2
`define HWRD_DATA_W     512
`define HWRD_BE_W       64
`define HWRD_CMP_W      3

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define HWRD_OPC_FULL    4'h1
`define HWRD_OPC_PART    4'h2
`define HWRD_SEL_STATE   2'h0
`define HWRD_SEL_NOOP    2'h3
`define HWRD_ST_INVALID  2'h0
`define HWRD_ST_RSVD     2'h1
`define HWRD_ST_ANY      2'h2
`define HWRD_ST_SHARED   2'h3
`define HWRD_SNP_NOOP    3'h0
`define HWRD_SNP_INV     3'h3
`define HWRD_CMP_PLAIN   3'h0

// ----------------------------------------------------------------------
// buffering
// ----------------------------------------------------------------------
`define HWRD_FIFO_DEPTH  32

`endif

// [common/hwrd_pkg.sv]
// types shared by the host write request decoder
package hwrd_pkg;

  // ----------------------------------------------------------------------
  // one buffered request with data
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]   write_operation_code;
    logic [1:0]   metadata_selector;
    logic [1:0]   metadata_new_value;
    logic [2:0]   snoop_kind;
    logic [45:0]  line_addr;
    logic [15:0]  tag;
    logic         poison;
    logic [511:0] data;
    logic [63:0]  byte_en;
  } hwrd_req_s;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HWRD_IDLE,
    HWRD_SNOOP,
    HWRD_WRITE,
    HWRD_RESP
  } hwrd_state_e;

endpackage

// [common/hwrd_stream_if.sv]
// valid/ready word stream between the decoder and its fifo
interface hwrd_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [hw/hwrd_fifo.sv]
// flip-flop fifo with valid/ready on both sides
module hwrd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic  clk_sys,    // system clock
  input  wire logic  rst_n,      // synchronous reset, active low
  hwrd_stream_if.snk fill,       // filling side
  hwrd_stream_if.src drain       // draining side
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [CW-1:0]           count;
    logic                    ready;
  } fifo_st_s;

  fifo_st_s r_ff;
  fifo_st_s nxt_r;
  logic     push;
  logic     pop;

  // ----------------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------------
  assign push        = fill.valid && r_ff.ready;
  assign pop         = drain.ready && (r_ff.count != '0);
  assign fill.ready  = r_ff.ready;
  assign drain.valid = (r_ff.count != '0);
  assign drain.data  = r_ff.mem[r_ff.rd_ptr];

  // pointers wrap at depth so depths that are not powers of two work
  always_comb
  begin
    nxt_r = r_ff;
    if (push)
    begin
      nxt_r.mem[r_ff.wr_ptr] = fill.data;
      nxt_r.wr_ptr = (r_ff.wr_ptr == AW'(DEPTH - 1)) ? '0
                     : AW'(r_ff.wr_ptr + 1'b1);
    end
    if (pop)
      nxt_r.rd_ptr = (r_ff.rd_ptr == AW'(DEPTH - 1)) ? '0
                     : AW'(r_ff.rd_ptr + 1'b1);
    if (push && !pop)
      nxt_r.count = CW'(r_ff.count + 1'b1);
    else if (pop && !push)
      nxt_r.count = CW'(r_ff.count - 1'b1);
    // ready is registered so the top port comes from a flop
    nxt_r.ready = (nxt_r.count != CW'(DEPTH));
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      r_ff       <= '0;
      r_ff.ready <= 1'b1;
    end
    else
      r_ff <= nxt_r;
  end

endmodule

// [hw/hwrd_decoder.sv]
// host-to-device request with data decoder and write sequencer
// ----------------------------------------------------------------------
// Functional notes
// - request is taken only while its valid flag is high
// - four-bit write operation code selects the operation performed
// - two-bit metadata selector names which metadata field to update
// - metadata selector is decoded even without metadata storage
// - metadata new value gives the field value when selector not no-op
// - metadata new value is decoded into a host intent hint when selector is 00 and value is not 01
// - three-bit snoop kind says which snoop the engine issues
// - 46-bit field carries line address bits 51 down to 6
// - sixteen-bit tag is echoed unchanged in the completion
// - two-bit traffic class is accepted and given no meaning
// - poison bit travels with the write to memory
// - code 0001 full-line write applies metadata and requested snoop
// - full write hitting modified line invalidates it, stores host data
// - code 0010 partial write writes only the enabled bytes
// - partial write hitting modified line merges, invalidates, writes
// - full write, state invalid, no snoop: write and plain completion
// - full write, state any, no snoop: write and plain completion
// - full write, invalid, snoop-invalidate: snoop first, then write
// - partial write, invalid, snoop-invalidate: merge, write, complete
// - plain completion is a no-data response with code 000
// - selector 00 selects coherence state, 11 means no metadata update
// - state 00 no copy, 10 any copy, 11 at most shared
// - snoop 000 none, 011 snoop-invalidate for exclusive copy
// ----------------------------------------------------------------------
`include "hwrd_map.svh"

module hwrd_decoder #(
  parameter int  FIFO_DEPTH   = `HWRD_FIFO_DEPTH,
  parameter bit  META_SUPPORT = 1'b1
) (
  input  wire logic         clk_sys,               // system clock
  input  wire logic         rst_n,                 // sync reset, active low
  // request with data from the host
  input  wire logic         req_valid,             // request valid flag
  output logic              req_ready,             // fifo has room
  input  wire logic [3:0]   req_write_operation_code, // operation
  input  wire logic [1:0]   req_metadata_selector, // metadata field
  input  wire logic [1:0]   req_metadata_new_value, // metadata value
  input  wire logic [2:0]   req_snoop_kind,        // snoop request
  input  wire logic [45:0]  req_line_addr,         // address bits 51..6
  input  wire logic [15:0]  req_tag,               // host source entry
  input  wire logic [1:0]   req_traffic_class_field, // no meaning here
  input  wire logic         req_poison,            // data is erroneous
  input  wire logic [511:0] req_data,              // line data
  input  wire logic [63:0]  req_byte_en,           // partial enables
  // device coherence engine snoop port
  output logic              snp_valid,             // snoop request
  output logic [2:0]        snp_kind,              // snoop kind to issue
  output logic [45:0]       snp_line_addr,         // snooped line
  output logic              snp_invalidate,        // drop cached copy
  input  wire logic         snp_done,              // snoop finished pulse
  input  wire logic         snp_hit_modified,      // cache held dirty line
  input  wire logic [511:0] snp_line,              // dirty cached line
  // device memory write port
  output logic              mem_wr_valid,          // write request
  output logic [45:0]       mem_wr_addr,           // line address
  output logic [511:0]      mem_wr_data,           // line data
  output logic [63:0]       mem_wr_byte_en,        // byte enables
  output logic              mem_wr_poison,         // poisoned data
  input  wire logic         mem_wr_ready,          // memory takes write
  // metadata and host intent
  output logic              meta_wr_en,            // metadata update pulse
  output logic [1:0]        meta_wr_value,         // new coherence state
  output logic              host_hint_valid,       // hint below is live
  output logic [1:0]        host_hint_state,       // host copy state
  // completion to the host
  output logic              cmp_valid,             // completion valid
  output logic [2:0]        cmp_opcode,            // completion code
  output logic [15:0]       cmp_tag,               // echoed tag
  output logic [1:0]        cmp_metadata_selector, // echoed selector
  output logic [1:0]        cmp_metadata_new_value, // echoed value
  input  wire logic         cmp_ready              // host takes completion
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    hwrd_pkg::hwrd_state_e state;
    hwrd_pkg::hwrd_req_s   req;
    logic                  snp_valid;
    logic [2:0]            snp_kind;
    logic                  mem_wr_valid;
    logic [511:0]          mem_wr_data;
    logic [63:0]           mem_wr_byte_en;
    logic                  meta_wr_en;
    logic [1:0]            meta_wr_value;
    logic                  hint_valid;
    logic [1:0]            hint_state;
    logic                  cmp_valid;
  } dec_st_s;

  localparam int RW = $bits(hwrd_pkg::hwrd_req_s);

  dec_st_s               r_ff;
  dec_st_s               nxt_r;
  hwrd_pkg::hwrd_req_s   head;
  hwrd_pkg::hwrd_req_s   in_word;
  logic [511:0]          merged;

  hwrd_stream_if #(.W(RW)) fill_if ();
  hwrd_stream_if #(.W(RW)) drain_if ();

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // reserved codes fall out here, so they never reach memory
  function automatic logic is_write(input logic [3:0] opc);
    is_write = (opc == `HWRD_OPC_FULL) || (opc == `HWRD_OPC_PART);
  endfunction

  // reserved 1xx kinds are not issued to the engine
  function automatic logic wants_snoop(input logic [2:0] kind);
    wants_snoop = (kind != `HWRD_SNP_NOOP) && !kind[2];
  endfunction

  function automatic logic is_partial(input logic [3:0] opc);
    is_partial = (opc == `HWRD_OPC_PART);
  endfunction

  function automatic logic state_update(input logic [1:0] sel);
    state_update = (sel == `HWRD_SEL_STATE);
  endfunction

  // ----------------------------------------------------------------------
  // request capture into the fifo
  // ----------------------------------------------------------------------
  // traffic class is deliberately dropped: it steers nothing
  always_comb
  begin
    in_word                      = '0;
    in_word.write_operation_code = req_write_operation_code;
    in_word.metadata_selector    = req_metadata_selector;
    in_word.metadata_new_value   = req_metadata_new_value;
    in_word.snoop_kind           = req_snoop_kind;
    in_word.line_addr            = req_line_addr;
    in_word.tag                  = req_tag;
    in_word.poison               = req_poison;
    in_word.data                 = req_data;
    in_word.byte_en              = req_byte_en;
  end

  assign fill_if.valid  = req_valid;
  assign fill_if.data   = in_word;
  assign req_ready      = fill_if.ready;
  assign head           = hwrd_pkg::hwrd_req_s'(drain_if.data);
  // one request is worked on at a time; the fifo absorbs the rest
  assign drain_if.ready = (r_ff.state == hwrd_pkg::HWRD_IDLE);

  hwrd_fifo #(
    .W     (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fill    (fill_if),
    .drain   (drain_if)
  );

  // ----------------------------------------------------------------------
  // merge of host bytes over a dirty cached line
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int b = 0; b < `HWRD_BE_W; b++)
      merged[b*8 +: 8] = r_ff.req.byte_en[b] ? r_ff.req.data[b*8 +: 8]
                         : snp_line[b*8 +: 8];
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_r            = r_ff;
    nxt_r.meta_wr_en = 1'b0;
    unique case (r_ff.state)
      hwrd_pkg::HWRD_IDLE:
      begin
        if (drain_if.valid)
        begin
          nxt_r.req = head;
          // intent is read even where no metadata is stored
          nxt_r.hint_valid = state_update(head.metadata_selector)
                             && (head.metadata_new_value
                                 != `HWRD_ST_RSVD);
          if (nxt_r.hint_valid)
            nxt_r.hint_state = head.metadata_new_value;
          if (!is_write(head.write_operation_code))
          begin
            nxt_r.cmp_valid = 1'b1;
            nxt_r.state     = hwrd_pkg::HWRD_RESP;
          end
          else if (wants_snoop(head.snoop_kind))
          begin
            // snoop before the write so stale dirty data cannot win
            nxt_r.snp_valid = 1'b1;
            nxt_r.snp_kind  = head.snoop_kind;
            nxt_r.state     = hwrd_pkg::HWRD_SNOOP;
          end
          else
          begin
            nxt_r.mem_wr_valid   = 1'b1;
            nxt_r.mem_wr_data    = head.data;
            nxt_r.mem_wr_byte_en = is_partial(head.write_operation_code)
                                   ? head.byte_en : '1;
            nxt_r.state          = hwrd_pkg::HWRD_WRITE;
          end
        end
      end
      hwrd_pkg::HWRD_SNOOP:
      begin
        if (snp_done)
        begin
          nxt_r.snp_valid    = 1'b0;
          nxt_r.mem_wr_valid = 1'b1;
          if (is_partial(r_ff.req.write_operation_code))
          begin
            // a dirty hit turns the partial write into a full merged line
            nxt_r.mem_wr_data    = snp_hit_modified ? merged
                                   : r_ff.req.data;
            nxt_r.mem_wr_byte_en = snp_hit_modified ? '1
                                   : r_ff.req.byte_en;
          end
          else
          begin
            nxt_r.mem_wr_data    = r_ff.req.data;
            nxt_r.mem_wr_byte_en = '1;
          end
          nxt_r.state = hwrd_pkg::HWRD_WRITE;
        end
      end
      hwrd_pkg::HWRD_WRITE:
      begin
        if (mem_wr_ready)
        begin
          nxt_r.mem_wr_valid = 1'b0;
          nxt_r.meta_wr_en   = META_SUPPORT
                               && state_update(r_ff.req.metadata_selector)
                               && (r_ff.req.metadata_new_value
                                   != `HWRD_ST_RSVD);
          nxt_r.meta_wr_value = r_ff.req.metadata_new_value;
          nxt_r.cmp_valid     = 1'b1;
          nxt_r.state         = hwrd_pkg::HWRD_RESP;
        end
      end
      hwrd_pkg::HWRD_RESP:
      begin
        if (cmp_ready)
        begin
          nxt_r.cmp_valid = 1'b0;
          nxt_r.state     = hwrd_pkg::HWRD_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  // ----------------------------------------------------------------------
  // outputs, all but the constant cmp_opcode taken from the state register
  // ----------------------------------------------------------------------
  assign snp_valid              = r_ff.snp_valid;
  assign snp_kind               = r_ff.snp_kind;
  assign snp_line_addr          = r_ff.req.line_addr;
  // every snoop for a write drops the cached copy the host overwrites
  assign snp_invalidate         = r_ff.snp_valid;
  assign mem_wr_valid           = r_ff.mem_wr_valid;
  assign mem_wr_addr            = r_ff.req.line_addr;
  assign mem_wr_data            = r_ff.mem_wr_data;
  assign mem_wr_byte_en         = r_ff.mem_wr_byte_en;
  // poisoned data is written but flagged so memory can mark it bad
  assign mem_wr_poison          = r_ff.req.poison;
  assign meta_wr_en             = r_ff.meta_wr_en;
  assign meta_wr_value          = r_ff.meta_wr_value;
  assign host_hint_valid        = r_ff.hint_valid;
  assign host_hint_state        = r_ff.hint_state;
  assign cmp_valid              = r_ff.cmp_valid;
  assign cmp_opcode             = `HWRD_CMP_PLAIN;
  assign cmp_tag                = r_ff.req.tag;
  assign cmp_metadata_selector  = r_ff.req.metadata_selector;
  assign cmp_metadata_new_value = r_ff.req.metadata_new_value;

endmodule

// [tb/hwrd_decoder_props.sv]
// concurrent checks on the host write request decoder ports
module hwrd_decoder_props (
  input wire logic        clk_sys,      // system clock
  input wire logic        rst_n,        // sync reset, active low
  input wire logic        req_ready,    // fifo has room
  input wire logic        snp_valid,    // snoop request
  input wire logic [2:0]  snp_kind,     // snoop kind issued
  input wire logic        snp_done,     // snoop finished pulse
  input wire logic        mem_wr_valid, // memory write request
  input wire logic        mem_wr_ready, // memory takes write
  input wire logic        meta_wr_en,   // metadata update pulse
  input wire logic        cmp_valid,    // completion valid
  input wire logic [2:0]  cmp_opcode,   // completion code
  input wire logic [15:0] cmp_tag,      // echoed tag
  input wire logic        cmp_ready     // host takes completion
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once for all checks
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_cmp_plain_code:
    assert property (cmp_valid |-> cmp_opcode == 3'h0)
      else $error("completion code is not plain");
  chk_snp_kind_live:
    assert property (snp_valid |-> snp_kind inside {3'h1, 3'h2, 3'h3})
      else $error("snoop issued for a no-snoop kind");
  chk_snp_held:
    assert property (snp_valid && !snp_done |=> snp_valid && $stable(snp_kind))
      else $error("snoop request dropped before done");
  chk_snp_then_write:
    assert property (snp_valid && snp_done |=> !snp_valid && mem_wr_valid)
      else $error("write does not follow finished snoop");
  chk_mem_held:
    assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid)
      else $error("memory write withdrawn before taken");
  chk_write_then_cmp:
    assert property (mem_wr_valid && mem_wr_ready |=> !mem_wr_valid && cmp_valid)
      else $error("completion does not follow memory write");
  chk_cmp_tag_held:
    assert property (cmp_valid && !cmp_ready |=> cmp_valid && $stable(cmp_tag))
      else $error("completion or its tag changed before taken");
  chk_meta_with_cmp:
    assert property (meta_wr_en |-> cmp_valid && !mem_wr_valid ##1 !meta_wr_en)
      else $error("metadata update outside write completion");

  cover property (snp_valid && snp_done);
  cover property (mem_wr_valid && mem_wr_ready && cmp_ready);
  cover property (!req_ready);
endmodule

bind hwrd_decoder hwrd_decoder_props u_props (.*);

// [tb/hwrd_far_model.sv]
// stand-in for the snoop filter, device memory and completion sink
module hwrd_far_model #(
  parameter logic [511:0] LINE = '0
) (
  input  wire logic    clk_sys,          // system clock
  input  wire logic    rst_n,            // sync reset, active low
  input  wire logic    slow,             // answer late and stall
  input  wire logic    hold,             // refuse completions
  input  wire logic    hit,              // report a dirty hit
  input  wire logic    snp_valid,        // snoop request
  output logic         snp_done,         // snoop finished pulse
  output logic         snp_hit_modified, // dirty hit flag
  output logic [511:0] snp_line,         // dirty cached line
  output logic         mem_wr_ready,     // memory takes write
  output logic         cmp_ready         // host takes completion
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;
  logic       tgl_ff;

  // one done pulse per snoop, after a short or a long lookup
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      snp_done <= 1'b0;
      wait_ff  <= 2'h0;
      tgl_ff   <= 1'b0;
    end
    else
    begin
      tgl_ff   <= !tgl_ff;
      snp_done <= snp_valid && !snp_done && (!slow || wait_ff == 2'h3);
      wait_ff  <= (snp_valid && !snp_done) ? wait_ff + 2'h1 : 2'h0;
    end
  end

  // outside the done cycle the lines show the inverse, so stale use shows
  assign snp_hit_modified = snp_done ? hit : !hit;
  assign snp_line         = snp_done ? LINE : ~LINE;
  assign mem_wr_ready     = !slow || tgl_ff;
  assign cmp_ready        = !hold && (!slow || tgl_ff);
endmodule

// [tb/tb.sv]
// self-checking bench for the host write request decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [511:0] D = {16{32'hA5C3_0F1E}};
  localparam logic [511:0] L = {16{32'h5A5A_3C3C}};
  localparam logic [45:0]  A = 46'h0123_4567_89AB;
  typedef struct packed {
    logic [3:0]  op;
    logic [1:0]  sel;
    logic [1:0]  val;
    logic [2:0]  snp;
    logic        hit;
    logic [63:0] be;
  } hwrd_row_s;

  logic         clk_sys, rst_n, req_valid, req_ready, req_poison;
  logic [3:0]   req_write_operation_code;
  logic [1:0]   req_metadata_selector, req_metadata_new_value;
  logic [1:0]   req_traffic_class_field, meta_wr_value, host_hint_state;
  logic [1:0]   cmp_metadata_selector, cmp_metadata_new_value, m_val;
  logic [2:0]   req_snoop_kind, snp_kind, cmp_opcode, s_kind, c_op;
  logic [45:0]  req_line_addr, snp_line_addr, mem_wr_addr, w_addr, s_addr;
  logic [15:0]  req_tag, cmp_tag, c_tag;
  logic [511:0] req_data, snp_line, mem_wr_data, w_data;
  logic [63:0]  req_byte_en, mem_wr_byte_en, w_be;
  logic         snp_valid, snp_invalidate, snp_done, snp_hit_modified;
  logic         mem_wr_valid, mem_wr_poison, mem_wr_ready, meta_wr_en;
  logic         host_hint_valid, cmp_valid, cmp_ready, w_pois;
  logic         slow, hold, hit, acc, s_inv;
  int           n_mismatch, samples_checked, n_wr, n_snp, n_cmp, n_meta;
  hwrd_row_s    rows [10];

`define CHK(a, b) \
  begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end

  hwrd_decoder #(.FIFO_DEPTH(4)) uut (.*);
  hwrd_far_model #(.LINE(L)) far (.*);

  always #2 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // monitor: what crossed each handshake at the last edge
  // ----------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    acc <= req_valid && req_ready;
    if (snp_valid && snp_done)
    begin
      n_snp++;
      {s_inv, s_addr, s_kind} = {snp_invalidate, snp_line_addr, snp_kind};
    end
    if (mem_wr_valid && mem_wr_ready)
    begin
      n_wr++;
      {w_addr, w_data} = {mem_wr_addr, mem_wr_data};
      {w_be, w_pois} = {mem_wr_byte_en, mem_wr_poison};
    end
    if (cmp_valid && cmp_ready)
    begin
      n_cmp++;
      {c_tag, c_op} = {cmp_tag, cmp_opcode};
    end
    if (meta_wr_en)
    begin
      n_meta++;
      m_val = meta_wr_value;
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // inputs always move 1 ns after the edge, never on it
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic load(input hwrd_row_s r, input logic [15:0] t);
    req_write_operation_code = r.op;
    req_metadata_selector = r.sel;
    req_metadata_new_value = r.val;
    req_snoop_kind = r.snp;
    req_byte_en = r.be;
    req_tag = t;
    req_traffic_class_field = t[1:0];
    req_poison = t[0];
    req_line_addr = A;
    req_data = D;
  endtask

  // request held until the edge that saw ready high
  task automatic send(input hwrd_row_s r, input logic [15:0] t);
    load(r, t);
    req_valid = 1'b1;
    for (int i = 0; i < 200 && !acc; i++)
      tick();
    `CHK(acc, 1'b1)
    if (!acc)
      finish_test();
    req_valid = 1'b0;
  endtask

  task automatic wait_cmp(input int k);
    for (int i = 0; i < 200 && n_cmp != k; i++)
      tick();
    `CHK(n_cmp, k)
    if (n_cmp != k)
      finish_test();
  endtask

  function automatic logic [511:0] merge(input logic [63:0] be);
    logic [511:0] m;
    for (int b = 0; b < 64; b++)
      m[8*b +: 8] = be[b] ? D[8*b +: 8] : L[8*b +: 8];
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    int k, b_wr, b_snp, b_meta, b_cmp;
    hwrd_row_s r;
    logic wr, sn, md;
    {clk_sys, rst_n, req_valid, slow, hold, hit} = 6'h00;
    load('0, 16'h0);
    rows[0] = '{4'h1, 2'h0, 2'h0, 3'h0, 1'b0, 64'h0};
    rows[1] = '{4'h1, 2'h0, 2'h2, 3'h0, 1'b0, 64'h0};
    rows[2] = '{4'h1, 2'h0, 2'h0, 3'h3, 1'b1, 64'h0};
    rows[3] = '{4'h2, 2'h0, 2'h0, 3'h3, 1'b1, 64'h00FF_0000_F0F0_0001};
    rows[4] = '{4'h2, 2'h3, 2'h2, 3'h0, 1'b0, 64'h8000_0000_0000_0003};
    rows[5] = '{4'h1, 2'h3, 2'h3, 3'h1, 1'b0, 64'h0};
    rows[6] = '{4'h0, 2'h0, 2'h0, 3'h3, 1'b0, 64'h0};
    rows[7] = '{4'hF, 2'h3, 2'h0, 3'h0, 1'b0, 64'h0};
    rows[8] = '{4'h1, 2'h0, 2'h3, 3'h4, 1'b0, 64'h0};
    rows[9] = '{4'h1, 2'h0, 2'h1, 3'h2, 1'b1, 64'h0};
    repeat (3) tick();
    `CHK(req_ready, 1'b1)
    `CHK({snp_valid, mem_wr_valid, cmp_valid, meta_wr_en}, 4'h0)
    rst_n = 1'b1;
    $display("reset test done");
    // every row once with a prompt far side, once with a stalling one
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 10; i++)
      begin
        r = rows[i];
        slow = p[0];
        hit = r.hit;
        wr = r.op == 4'h1 || r.op == 4'h2;
        sn = wr && r.snp inside {3'h1, 3'h2, 3'h3};
        md = wr && r.sel == 2'h0 && r.val != 2'h1;
        {b_wr, b_snp, b_meta, b_cmp} = {n_wr, n_snp, n_meta, n_cmp};
        send(r, 16'h1000 + 16'(i));
        wait_cmp(b_cmp + 1);
        `CHK(n_wr - b_wr, int'(wr))
        `CHK(n_snp - b_snp, int'(sn))
        `CHK(n_meta - b_meta, int'(md))
        `CHK(c_tag, 16'h1000 + 16'(i))
        `CHK(c_op, 3'h0)
        if (sn)
          `CHK(s_kind, r.snp)
        if (sn)
          `CHK({s_inv, s_addr}, {1'b1, A})
        if (md)
          `CHK(host_hint_state, r.val)
        `CHK(cmp_metadata_selector, r.sel)
        `CHK(cmp_metadata_new_value, r.val)
        if (md)
          `CHK(m_val, r.val)
        if (wr)
        begin
          `CHK(w_addr, A)
          `CHK(w_pois, i[0])
          `CHK(host_hint_valid, md)
          `CHK(w_data, (r.op == 4'h2 && sn && r.hit) ? merge(r.be) : D)
          `CHK(w_be, (r.op == 4'h2 && !(sn && r.hit)) ? r.be : '1)
        end
        $display("row %0d pass %0d done", i, p);
      end
    // back to back into a stalled decoder until the fifo refuses
    {slow, hold, k, b_cmp} = {2'b01, 32'd0, n_cmp};
    req_valid = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      load(rows[6], 16'h2000 + 16'(i));
      tick();
      if (!acc)
        break;
      k++;
    end
    req_valid = 1'b0;
    `CHK(k, 5)
    `CHK(req_ready, 1'b0)
    hold = 1'b0;
    wait_cmp(b_cmp + 5);
    `CHK(c_tag, 16'h2004)
    $display("fill test done");
    // a well-formed write with its valid flag low is never acted on
    b_cmp = n_cmp;
    load(rows[0], 16'h3000);
    repeat (8) tick();
    `CHK(n_cmp, b_cmp)
    $display("idle test done");
    finish_test();
  end
endmodule
